/* File: sst_map.vh */
// sst_map.vh: register offsets, field positions, reset values and counts
// for the bus status and error tracking block.
// assumes: included by bare name by every design file of the block.
`ifndef SST_MAP_VH
`define SST_MAP_VH

// ************************************************************
// register byte addresses
// ************************************************************
`define SST_ADDR_W 12
`define SST_OFF_STATUS 12'h344
`define SST_OFF_CTRL 12'h348
`define SST_OFF_MASK 12'h34c

// ************************************************************
// status register fields
// ************************************************************
`define SST_SLV_ADDR_LSB 1
`define SST_SLV_ADDR_MSB 7
`define SST_MST_ADDR_LSB 9
`define SST_MST_ADDR_MSB 15
`define SST_BIT_DONE 24
`define SST_BIT_NOACK 25
`define SST_BIT_ARB 26
`define SST_BIT_COND 27
`define SST_BIT_CKSUM 28
`define SST_BIT_UNMAP 29
`define SST_EVT_LSB 24
`define SST_EVT_MSB 29
`define SST_EVT_W 6

// ************************************************************
// control register fields
// ************************************************************
`define SST_BIT_IGN_MASTERS 16
`define SST_BIT_IGN_CKSUM 17

// ************************************************************
// reset values and counts
// ************************************************************
`define SST_EVT_RST 6'h00
`define SST_CTRL_RST 2'h0
`define SST_MASK_RST 6'h00
`define SST_ARB_LIMIT 16
`define SST_ARB_CNT_W 5

`endif

/* File: sst_cond_det.v */
// sst_cond_det.v: samples the bus clock and data lines with the core
// clock and reports a start or stop condition seen while a byte is moving.
// assumes: the line inputs are asynchronous pins; byte_busy_i is on the
// core clock and high while the master engine shifts bits of a byte.
`timescale 1ns/1ps
`default_nettype none
`include "sst_map.vh"

module sst_cond_det (
  input wire clk_i,
  input wire srst_i,
  input wire scl_i,
  input wire sda_i,
  input wire byte_busy_i,
  output reg misplaced_o
);

  // ************************************************************
  // line synchronisers
  // ************************************************************
  reg scl_meta;
  reg sda_meta;
  reg scl_sync;
  reg sda_sync;
  reg scl_last;
  reg sda_last;
  wire start_seen;
  wire stop_seen;

  // two flops per line, then one more stage for edge finding
  always @(posedge clk_i) begin
    if (srst_i) begin
      scl_meta <= 1'b1;
      sda_meta <= 1'b1;
      scl_sync <= 1'b1;
      sda_sync <= 1'b1;
      scl_last <= 1'b1;
      sda_last <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      sda_meta <= sda_i;
      scl_sync <= scl_meta;
      sda_sync <= sda_meta;
      scl_last <= scl_sync;
      sda_last <= sda_sync;
    end
  end

  // ************************************************************
  // condition detection
  // ************************************************************
  // data falls (start) or rises (stop) while the clock stays high
  assign start_seen = scl_sync & scl_last & sda_last & ~sda_sync;
  assign stop_seen = scl_sync & scl_last & ~sda_last & sda_sync;

  // one-cycle pulse when a condition lands inside a byte
  always @(posedge clk_i) begin
    if (srst_i) begin
      misplaced_o <= 1'b0;
    end else begin
      misplaced_o <= byte_busy_i & (start_seen | stop_seen);
    end
  end

endmodule // sst_cond_det
`default_nettype wire

/* File: sst_status.v */
// sst_status.v: status, error tracking and arbitration retry control
// for the two serial management buses, with an apb register slave.
// assumes: event inputs are one-cycle pulses from engines on the core
// clock; address and mode inputs are stable while reset is held.
`timescale 1ns/1ps
`default_nettype none
`include "sst_map.vh"

module sst_status #(
  parameter ARB_LIMIT = `SST_ARB_LIMIT
) (
  input wire CORE_CLK_I,
  input wire SRST_I,
  // apb slave
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [`SST_ADDR_W-1:0] PADDR_I,
  input wire [31:0] PWDATA_I,
  output reg [31:0] PRDATA_O,
  output reg PREADY_O,
  output reg PSLVERR_O,
  // assigned addresses and load mode, held steady during reset
  input wire [6:0] SLV_ADDR_I,
  input wire [6:0] MST_ADDR_I,
  input wire LOAD_MODE_I,
  // bus lines of the master interface
  input wire MST_SCL_I,
  input wire MST_SDA_I,
  // master engine events
  input wire BYTE_BUSY_I,
  input wire NACK_I,
  input wire ARB_LOST_I,
  input wire ARB_WON_I,
  // rom loader events
  input wire LOAD_END_I,
  input wire LOAD_FAIL_I,
  input wire CKSUM_BAD_I,
  input wire CFG_DONE_SEEN_I,
  input wire UNMAPPED_WR_I,
  // outputs to the engines and system
  output reg ARB_RETRY_O,
  output reg XACT_ABORT_O,
  output reg IGNORE_MASTERS_O,
  output reg IGNORE_CKSUM_O,
  output reg IRQ_O
);

  // ************************************************************
  // declarations
  // ************************************************************
  reg [6:0] slave_bus_address;
  reg [6:0] master_bus_address;
  reg load_mode;
  reg [`SST_EVT_W-1:0] evt;
  reg [`SST_EVT_W-1:0] next_evt;
  reg [`SST_EVT_W-1:0] evt_set;
  reg [`SST_EVT_W-1:0] evt_mask;
  reg ignore_competing_masters;
  reg ignore_load_checksum;
  reg [`SST_ARB_CNT_W-1:0] arb_cnt;
  reg [`SST_ARB_CNT_W-1:0] next_arb_cnt;
  reg arb_abort;
  reg arb_retry;
  reg [31:0] smbus_status_flags;
  reg [31:0] rd_mux;
  reg rd_hit;
  wire misplaced;
  wire apb_setup_done;
  wire apb_commit;
  wire wr_status;
  wire wr_ctrl;
  wire wr_mask;
  wire cksum_fail;
  localparam [`SST_ARB_CNT_W-1:0] ARB_LAST = ARB_LIMIT - 1;

  // ************************************************************
  // captured addresses and mode
  // ************************************************************
  // follow the init inputs while reset is held, then freeze them
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      slave_bus_address <= SLV_ADDR_I;
      master_bus_address <= MST_ADDR_I;
      load_mode <= LOAD_MODE_I;
    end
  end

  // ************************************************************
  // misplaced condition detector
  // ************************************************************
  sst_cond_det i_sst_cond_det (
    .clk_i(CORE_CLK_I),
    .srst_i(SRST_I),
    .scl_i(MST_SCL_I),
    .sda_i(MST_SDA_I),
    .byte_busy_i(BYTE_BUSY_I),
    .misplaced_o(misplaced)
  );

  // ************************************************************
  // arbitration retry and abort
  // ************************************************************
  // consecutive loss count; a win or an abort starts it over
  always @* begin
    next_arb_cnt = arb_cnt;
    arb_abort = 1'b0;
    arb_retry = 1'b0;
    if (ignore_competing_masters) begin
      next_arb_cnt = {`SST_ARB_CNT_W{1'b0}};
    end else if (ARB_WON_I) begin
      next_arb_cnt = {`SST_ARB_CNT_W{1'b0}};
    end else if (ARB_LOST_I) begin
      if (arb_cnt == ARB_LAST) begin
        arb_abort = 1'b1;
        next_arb_cnt = {`SST_ARB_CNT_W{1'b0}};
      end else begin
        arb_retry = 1'b1;
        next_arb_cnt = arb_cnt + 1'b1;
      end
    end
  end

  // counter and one-cycle retry and abort pulses
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      arb_cnt <= {`SST_ARB_CNT_W{1'b0}};
      ARB_RETRY_O <= 1'b0;
      XACT_ABORT_O <= 1'b0;
    end else begin
      arb_cnt <= next_arb_cnt;
      ARB_RETRY_O <= arb_retry;
      XACT_ABORT_O <= arb_abort;
    end
  end

  // ************************************************************
  // event collection
  // ************************************************************
  // checksum counts as failing when bad and not ignored, or no done cmd
  assign cksum_fail = (CKSUM_BAD_I & ~ignore_load_checksum)
                      | ~CFG_DONE_SEEN_I;

  // set terms for each sticky bit, lsb is the done flag
  always @* begin
    evt_set = {`SST_EVT_W{1'b0}};
    evt_set[`SST_BIT_DONE-`SST_EVT_LSB] = load_mode
                                           & (LOAD_END_I | LOAD_FAIL_I);
    evt_set[`SST_BIT_NOACK-`SST_EVT_LSB] = NACK_I;
    evt_set[`SST_BIT_ARB-`SST_EVT_LSB] = arb_abort;
    evt_set[`SST_BIT_COND-`SST_EVT_LSB] = misplaced;
    evt_set[`SST_BIT_CKSUM-`SST_EVT_LSB] = load_mode & LOAD_END_I
                                            & cksum_fail;
    evt_set[`SST_BIT_UNMAP-`SST_EVT_LSB] = UNMAPPED_WR_I;
  end

  // ************************************************************
  // apb access decode
  // ************************************************************
  // pready rises one cycle into the access phase, commit on the edge after that
  assign apb_setup_done = PSEL_I & PENABLE_I & ~PREADY_O;
  assign apb_commit = PSEL_I & PENABLE_I & PREADY_O;
  assign wr_status = apb_commit & PWRITE_I & (PADDR_I == `SST_OFF_STATUS);
  assign wr_ctrl = apb_commit & PWRITE_I & (PADDR_I == `SST_OFF_CTRL);
  assign wr_mask = apb_commit & PWRITE_I & (PADDR_I == `SST_OFF_MASK);

  // ************************************************************
  // sticky status bits
  // ************************************************************
  // write one clears bits 25..29, done bit stays read-only;
  // a set arriving with a clear wins
  always @* begin
    next_evt = evt;
    if (wr_status) begin
      next_evt[`SST_EVT_W-1:1] = evt[`SST_EVT_W-1:1]
                                 & ~PWDATA_I[`SST_EVT_MSB:`SST_EVT_LSB+1];
    end
    next_evt = next_evt | evt_set;
  end

  // status flag storage
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      evt <= `SST_EVT_RST;
    end else begin
      evt <= next_evt;
    end
  end

  // ************************************************************
  // control and mask registers
  // ************************************************************
  // software writable control bits and interrupt mask
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      ignore_competing_masters <= 1'b0;
      ignore_load_checksum <= 1'b0;
      evt_mask <= `SST_MASK_RST;
    end else begin
      if (wr_ctrl) begin
        ignore_competing_masters <= PWDATA_I[`SST_BIT_IGN_MASTERS];
        ignore_load_checksum <= PWDATA_I[`SST_BIT_IGN_CKSUM];
      end
      if (wr_mask) begin
        evt_mask <= PWDATA_I[`SST_EVT_MSB:`SST_EVT_LSB];
      end
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // full status word, reserved bits held at zero
  always @* begin
    smbus_status_flags = 32'h0000_0000;
    smbus_status_flags[`SST_SLV_ADDR_MSB:`SST_SLV_ADDR_LSB] = slave_bus_address;
    smbus_status_flags[`SST_MST_ADDR_MSB:`SST_MST_ADDR_LSB] = master_bus_address;
    smbus_status_flags[`SST_EVT_MSB:`SST_EVT_LSB] = evt;
  end

  // register select, unmapped addresses flagged
  always @* begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (PADDR_I)
      `SST_OFF_STATUS: begin
        rd_mux = smbus_status_flags;
      end
      `SST_OFF_CTRL: begin
        rd_mux[`SST_BIT_IGN_MASTERS] = ignore_competing_masters;
        rd_mux[`SST_BIT_IGN_CKSUM] = ignore_load_checksum;
      end
      `SST_OFF_MASK: begin
        rd_mux[`SST_EVT_MSB:`SST_EVT_LSB] = evt_mask;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // ************************************************************
  // apb answer
  // ************************************************************
  // one wait state; data and error are held with pready for one cycle
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      PREADY_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else begin
      PREADY_O <= apb_setup_done;
      if (apb_setup_done) begin
        PRDATA_O <= PWRITE_I ? 32'h0000_0000 : rd_mux;
        PSLVERR_O <= ~rd_hit;
      end else begin
        PRDATA_O <= 32'h0000_0000;
        PSLVERR_O <= 1'b0;
      end
    end
  end

  // ************************************************************
  // interrupt and control outputs
  // ************************************************************
  // level interrupt from any unmasked sticky bit, registered on the same edge as that bit
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      IRQ_O <= 1'b0;
      IGNORE_MASTERS_O <= 1'b0;
      IGNORE_CKSUM_O <= 1'b0;
    end else begin
      IRQ_O <= |(next_evt & evt_mask);
      IGNORE_MASTERS_O <= ignore_competing_masters;
      IGNORE_CKSUM_O <= ignore_load_checksum;
    end
  end

endmodule // sst_status
`default_nettype wire

/* File: sst_status_properties.sv */
// sst_status_properties.sv: port timing and read data checks for the status block.
// assumes: bound to sst_status; one core clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "sst_map.vh"

module sst_status_props #(
  parameter ARB_LIMIT = 16
) (
  input wire CORE_CLK_I,
  input wire SRST_I,
  input wire PSEL_I,
  input wire PENABLE_I,
  input wire PWRITE_I,
  input wire [`SST_ADDR_W-1:0] PADDR_I,
  input wire [31:0] PRDATA_O,
  input wire PREADY_O,
  input wire PSLVERR_O,
  input wire [6:0] SLV_ADDR_I,
  input wire [6:0] MST_ADDR_I,
  input wire ARB_LOST_I,
  input wire ARB_WON_I,
  input wire ARB_RETRY_O,
  input wire XACT_ABORT_O,
  input wire IGNORE_MASTERS_O
);
  // ************************************************************
  // helper state and checks
  // ************************************************************
  reg [6:0] slv;
  reg [6:0] mst;
  reg [4:0] cnt;
  // address copies under reset, and a count of straight losses
  always @(posedge CORE_CLK_I) begin
    if (SRST_I) begin
      slv <= SLV_ADDR_I;
      mst <= MST_ADDR_I;
    end
    if (SRST_I || ARB_WON_I || IGNORE_MASTERS_O) cnt <= 5'h00;
    else if (ARB_LOST_I) cnt <= (cnt == ARB_LIMIT - 1) ? 5'h00 : cnt + 5'h01;
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (SRST_I);
  sequence s_access;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence
  sequence s_status_rd;
    PREADY_O && !PWRITE_I && PADDR_I == `SST_OFF_STATUS;
  endsequence
  sequence s_loss;
    ARB_LOST_I && !ARB_WON_I && !IGNORE_MASTERS_O;
  endsequence
  a_ready_one_wait: assert property (s_access |=> PREADY_O ##1 !PREADY_O)
    else $error("ready not a single pulse after access");
  a_status_addrs: assert property (s_status_rd |->
    PRDATA_O[7:1] == slv && PRDATA_O[15:9] == mst) else $error("address field wrong");
  a_reserved_zero: assert property (s_status_rd |-> PRDATA_O[0] == 1'b0 &&
    PRDATA_O[8] == 1'b0 && PRDATA_O[23:16] == 8'h00 && PRDATA_O[31:30] == 2'h0)
    else $error("reserved status bits not zero");
  a_slverr_map: assert property (PREADY_O |-> PSLVERR_O == (PADDR_I != `SST_OFF_STATUS
    && PADDR_I != `SST_OFF_CTRL && PADDR_I != `SST_OFF_MASK)) else $error("bad slverr");
  a_retry_loss: assert property (s_loss ##0 cnt != ARB_LIMIT - 1 |=>
    ARB_RETRY_O && !XACT_ABORT_O) else $error("no retry after loss");
  a_abort_limit: assert property (s_loss ##0 cnt == ARB_LIMIT - 1 |=>
    XACT_ABORT_O && !ARB_RETRY_O) else $error("no abort at loss limit");
  a_abort_cause: assert property (XACT_ABORT_O |->
    $past(ARB_LOST_I) && $past(cnt) == ARB_LIMIT - 1) else $error("abort without cause");
  a_ignore_quiet: assert property (IGNORE_MASTERS_O && ARB_LOST_I |=>
    !ARB_RETRY_O && !XACT_ABORT_O) else $error("loss acted on while ignored");
endmodule // sst_status_props

bind sst_status sst_status_props #(.ARB_LIMIT(ARB_LIMIT)) i_sst_status_props (
  .CORE_CLK_I(CORE_CLK_I), .SRST_I(SRST_I), .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I),
  .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O),
  .PSLVERR_O(PSLVERR_O), .SLV_ADDR_I(SLV_ADDR_I), .MST_ADDR_I(MST_ADDR_I),
  .ARB_LOST_I(ARB_LOST_I), .ARB_WON_I(ARB_WON_I), .ARB_RETRY_O(ARB_RETRY_O),
  .XACT_ABORT_O(XACT_ABORT_O), .IGNORE_MASTERS_O(IGNORE_MASTERS_O));
`default_nettype wire

/* File: sst_bus_model.sv */
// sst_bus_model.sv: far-side traffic on the master bus clock and data pins.
// assumes: lines pulled up; a rise on go_i starts one byte frame.
`timescale 1ns/1ps
`default_nettype none

module sst_bus_model (
  input wire logic go_i,
  input wire logic stray_i,
  output logic scl_o,
  output logic sda_o,
  output logic busy_o
);
  // ************************************************************
  // byte frame, 400 ns bit period, clock still between frames
  // ************************************************************
  integer k;
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
    busy_o = 1'b0;
  end
  // data moves while the clock is low, except the asked-for stray edge
  always @(posedge go_i) begin
    #13 busy_o = 1'b1;
    for (k = 0; k < 8; k = k + 1) begin
      scl_o = 1'b0;
      #100 sda_o = ~sda_o;
      #100 scl_o = 1'b1;
      #100 if (stray_i && k == 4) sda_o = ~sda_o; // condition mid-byte
      #100;
    end
    scl_o = 1'b0;
    busy_o = 1'b0;
    #100 sda_o = 1'b1; // release to the pull-up level
    #100 scl_o = 1'b1;
  end
endmodule // sst_bus_model
`default_nettype wire

/* File: tb_sst_status.sv */
// tb_sst_status.sv: self-checking bench for the status and error block.
// assumes: design, checker and bus model compiled before it.
`timescale 1ns/1ps
`default_nettype none
`include "sst_map.vh"

module tb_sst_status;
  // ************************************************************
  // stimulus, design and far-side model
  // ************************************************************
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] padr = 12'h000;
  logic [31:0] pwd = 32'h0;
  logic [6:0] slv = 7'h00;
  logic [6:0] mst = 7'h00;
  logic lmode = 1'b1;
  logic busy = 1'b0;
  logic nack, lost, won, lend, lfail, ckbad, cfgok, unmap, go, stray;
  wire [31:0] prd;
  wire prdy, perr, scl, sda, bb, retry, abort, ignm, ignc, irq;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_retry = 0;
  int n_abort = 0;
  int i;
  logic [31:0] rq, w;
  logic eq;
  logic [5:0] flg;
  logic [6:0] sc, mc;
  logic [2:0] tbl [4] = '{3'b110, 3'b111, 3'b001, 3'b010};

  sst_status #(.ARB_LIMIT(4)) i_sst_status (.CORE_CLK_I(clk), .SRST_I(srst),
    .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(padr), .PWDATA_I(pwd),
    .PRDATA_O(prd), .PREADY_O(prdy), .PSLVERR_O(perr), .SLV_ADDR_I(slv),
    .MST_ADDR_I(mst), .LOAD_MODE_I(lmode), .MST_SCL_I(scl), .MST_SDA_I(sda),
    .BYTE_BUSY_I(busy), .NACK_I(nack), .ARB_LOST_I(lost), .ARB_WON_I(won),
    .LOAD_END_I(lend), .LOAD_FAIL_I(lfail), .CKSUM_BAD_I(ckbad), .CFG_DONE_SEEN_I(cfgok),
    .UNMAPPED_WR_I(unmap), .ARB_RETRY_O(retry), .XACT_ABORT_O(abort),
    .IGNORE_MASTERS_O(ignm), .IGNORE_CKSUM_O(ignc), .IRQ_O(irq));
  sst_bus_model i_sst_bus_model (.go_i(go), .stray_i(stray), .scl_o(scl), .sda_o(sda),
    .busy_o(bb));

  // clock, engine busy window, pulse counters and hang guard
  always #25 clk = ~clk;
  always @(posedge clk) begin
    busy <= bb;
    n_retry += (retry === 1'b1);
    n_abort += (abort === 1'b1);
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ************************************************************
  // expectations, bus cycles and comparison
  // ************************************************************
  function automatic logic [31:0] stat();
    return {2'h0, flg, 8'h00, mc, 1'b0, sc, 1'b0};
  endfunction
  function automatic logic unm(input logic [11:0] a);
    return !(a == `SST_OFF_STATUS || a == `SST_OFF_CTRL || a == `SST_OFF_MASK);
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwr <= wr;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (prdy !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    chk({31'h0, prdy}, 32'h1);
    rq = prd;
    eq = perr;
    psel <= 1'b0;
    pen <= 1'b0;
    // one idle edge so a following call never re-drives psel in this step
    @(posedge clk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rq, e);
    chk({31'h0, eq}, {31'h0, unm(a)});
  endtask
  // losses, with a win at step wat when wat is below n
  task automatic arb(input int n, input int wat);
    for (int k = 0; k < n; k++) begin
      won <= (k == wat);
      lost <= (k != wat);
      @(posedge clk);
      won <= 1'b0;
      lost <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic tdone(input string s);
    $display("test %0s done", s);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {nack, lost, won, lend, lfail, ckbad, cfgok, unmap, go, stray} = 10'h000;
    void'($urandom(32'hefdc));
    w = $urandom;
    sc = w[6:0];
    mc = w[14:8];
    slv = sc;
    mst = mc;
    flg = 6'h00;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    slv <= ~sc;
    mst <= ~mc;
    rchk(`SST_OFF_STATUS, stat());
    rchk(`SST_OFF_CTRL, 32'h0);
    rchk(`SST_OFF_MASK, 32'h0);
    w = $urandom;
    rchk({2'h1, w[7:0], 2'h0}, 32'h0);
    apb(1'b1, `SST_OFF_STATUS, 32'hffffffff);
    rchk(`SST_OFF_STATUS, stat());
    tdone("reset values");
    for (i = 0; i < 2; i++) begin
      nack <= (i == 0);
      unmap <= (i == 1);
      @(posedge clk);
      nack <= 1'b0;
      unmap <= 1'b0;
      flg[i * 4 + 1] = 1'b1;
      rchk(`SST_OFF_STATUS, stat());
    end
    apb(1'b1, `SST_OFF_MASK, 32'h02000000);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    w = $urandom | 32'h02000000;
    apb(1'b1, `SST_OFF_STATUS, w);
    flg[5:1] = flg[5:1] & ~w[29:25];
    rchk(`SST_OFF_STATUS, stat());
    chk({31'h0, irq}, 32'h0);
    tdone("events and irq");
    lfail <= 1'b1;
    @(posedge clk);
    lfail <= 1'b0;
    flg[0] = 1'b1;
    rchk(`SST_OFF_STATUS, stat());
    for (i = 0; i < 4; i++) begin
      apb(1'b1, `SST_OFF_CTRL, {14'h0, tbl[i][0], 17'h0});
      repeat (2) @(posedge clk);
      ckbad <= tbl[i][2];
      cfgok <= tbl[i][1];
      lend <= 1'b1;
      @(posedge clk);
      lend <= 1'b0;
      flg[4] = (tbl[i][2] & ~tbl[i][0]) | ~tbl[i][1];
      rchk(`SST_OFF_STATUS, stat());
      chk({31'h0, ignc}, {31'h0, tbl[i][0]});
      apb(1'b1, `SST_OFF_STATUS, 32'h10000000);
      flg[4] = 1'b0;
    end
    tdone("rom load");
    arb(8, 3);
    flg[2] = 1'b1;
    rchk(`SST_OFF_STATUS, stat());
    chk(n_retry, 6);
    chk(n_abort, 1);
    apb(1'b1, `SST_OFF_STATUS, 32'h04000000);
    apb(1'b1, `SST_OFF_CTRL, 32'h00010000);
    flg[2] = 1'b0;
    repeat (2) @(posedge clk);
    arb(6, 9);
    rchk(`SST_OFF_STATUS, stat());
    chk(n_retry + n_abort * 10, 16);
    chk({31'h0, ignm}, 32'h1);
    tdone("arbitration");
    apb(1'b1, `SST_OFF_CTRL, 32'h0);
    for (i = 0; i < 2; i++) begin
      stray <= i[0];
      go <= 1'b1;
      repeat (80) @(posedge clk);
      go <= 1'b0;
      flg[3] = i[0];
      rchk(`SST_OFF_STATUS, stat());
    end
    tdone("misplaced condition");
    w = $urandom;
    sc = w[6:0];
    mc = w[14:8];
    srst <= 1'b1;
    lmode <= 1'b0;
    slv <= sc;
    mst <= mc;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    flg = 6'h00;
    lfail <= 1'b1;
    @(posedge clk);
    lfail <= 1'b0;
    rchk(`SST_OFF_STATUS, stat());
    tdone("second reset");
    report_and_stop();
  end
endmodule // tb_sst_status
`default_nettype wire
